/* rtl/detector_mode_sequencer.sv */
`timescale 1ns/1ns
`include "dms_map.svh"
// Detector mode sequencer: frame and bucket timing around the peak detectors.
module detector_mode_sequencer
  import dms_pkg::*;
#(
  parameter int FRAME_TICKS = `DMS_FRAME_US
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic positive_holding,
  input wire logic negative_holding,
  output logic hold_strobe,
  output logic odd_bucket_toggle,
  output logic pos_peak_reset_n,
  output logic negative_peak_input_reset_n,
  output logic video_select_a,
  output logic video_select_b,
  output logic noise_flag,
  output logic sweep_active,
  output logic converter_clock,
  output logic [2:0] converter_input
);
  localparam int CONV_DIV = `DMS_CONV_DIV;
  localparam int RST_CYC = (`DMS_RST_CYC < 1) ? 1 : `DMS_RST_CYC;

  // Control register: [1:0] mode, [2] sweep run, [3] wide sweep,
  // [4] diagnostic routine, [7:5] diagnostic input choice.
  typedef struct packed
  {
    logic [6:0] divCnt;
    logic convClk;
    logic [7:0] frameUs;
    logic [7:0] rstCnt;
    logic [7:0] rstCnt2;
    logic [31:0] bucketUs;
    logic [9:0] bucketNum;
    logic holdOut;
    logic oddOut;
    logic posRstN;
    logic negRstN;
    logic selA;
    logic selB;
    logic posSeen;
    logic negSeen;
    logic noiseOut;
    logic sweepOut;
    logic [2:0] convIn;
  } dms_state_t;
  dms_state_t st;
  dms_state_t next_st;

  logic [31:0] ctrlReg;
  logic [31:0] sweepReg;
  logic [1:0] holdSync;
  dms_mode_t mode;
  logic runSweep;
  logic wideSweep;
  logic diagRun;
  logic [2:0] diagPick;
  logic [31:0] bucketLen;
  logic [31:0] statusWord;

  // Software setting decode; mode changes only by processor write.
  assign mode = dms_mode_t'(ctrlReg[1:0]);
  assign runSweep = ctrlReg[2];
  assign wideSweep = ctrlReg[3];
  assign diagRun = ctrlReg[4];
  assign diagPick = ctrlReg[7:5];
  // Sweep register holds the sweep time in microseconds.
  assign bucketLen = sweepReg / `DMS_BUCKETS;
  assign statusWord = {20'h0_0000, st.bucketNum, st.noiseOut, st.sweepOut};

  dms_axil u_axil
  (
    .clk(clk),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .statusWord(statusWord),
    .ctrlReg(ctrlReg),
    .sweepReg(sweepReg)
  );

  dms_sync #(.WIDTH(2)) u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({positive_holding, negative_holding}),
    .syncOut(holdSync)
  );

  // Pick the converter input: diagnostic codes 4 to 7 in retrace or during the diagnostic routine, ramp for wide sweeps,
  // otherwise the detector matching the mode.
  function automatic logic [2:0] pickInput(input dms_mode_t m,
    input logic sweeping, input logic wide, input logic diag,
    input logic [2:0] pick, input logic posPhase);
    logic [2:0] r;
    r = DMS_IN_SAMPLED;
    if ((diag || !sweeping) && pick[2])
      r = pick;
    else if (wide && sweeping)
      r = DMS_IN_RAMP;
    else
      unique case (m)
        DMS_SAMPLE: r = DMS_IN_SAMPLED;
        DMS_POSPK: r = DMS_IN_POSPK;
        DMS_NEGPK: r = DMS_IN_NEGPK;
        DMS_NORMAL: r = posPhase ? DMS_IN_POSPK : DMS_IN_NEGPK;
      endcase
    return r;
  endfunction

  // Microsecond ticks, frame timing, bucket timing and pulse generation.
  always_comb
  begin
    logic tick;
    logic frameStart;
    logic bucketEnd;
    logic [7:0] fUs;
    next_st = st;
    tick = 1'b0;
    frameStart = 1'b0;
    bucketEnd = 1'b0;
    // 1 MHz converter clock from the divider.
    if (st.divCnt == 7'(CONV_DIV - 1))
    begin
      next_st.divCnt = '0;
      tick = 1'b1;
    end
    else
      next_st.divCnt = st.divCnt + 7'd1;
    next_st.convClk = (st.divCnt < 7'(CONV_DIV / 2));
    // Sweep active for the whole sweep, low in retrace.
    next_st.sweepOut = runSweep;
    if (tick && runSweep)
    begin
      if (st.frameUs == 8'(FRAME_TICKS - 1))
      begin
        next_st.frameUs = '0;
        frameStart = 1'b1;
      end
      else
        next_st.frameUs = st.frameUs + 8'd1;
      if (st.bucketUs + 32'd1 >= bucketLen)
      begin
        next_st.bucketUs = '0;
        bucketEnd = 1'b1;
      end
      else
        next_st.bucketUs = st.bucketUs + 32'd1;
    end
    // In retrace the frame counter parks on its last tick. The first tick of
    // a sweep then opens a whole frame, so the first hold pulse is full width.
    if (!runSweep)
    begin
      next_st.frameUs = 8'(FRAME_TICKS - 1);
      next_st.bucketUs = '0;
      next_st.bucketNum = '0;
    end
    fUs = next_st.frameUs;
    // Hold strobe 18 us per 128 us frame; freezes the track-and-hold.
    next_st.holdOut = runSweep && (fUs < 8'(`DMS_HOLD_US));
    // Select lines by mode; normal mode pulses them within each frame.
    unique case (mode)
      DMS_NORMAL:
      begin
        next_st.selA = runSweep && (fUs < 8'(`DMS_SELA_US));
        next_st.selB = runSweep && (fUs < 8'(`DMS_SELB_US));
      end
      DMS_SAMPLE:
      begin
        next_st.selA = 1'b1;
        next_st.selB = 1'b1;
      end
      DMS_POSPK:
      begin
        next_st.selA = 1'b1;
        next_st.selB = 1'b0;
      end
      DMS_NEGPK:
      begin
        next_st.selA = 1'b0;
        next_st.selB = 1'b1;
      end
    endcase
    // Reset pulse counters; the positive line waits on the first, the negative line on both.
    if (st.rstCnt != 8'd0)
      next_st.rstCnt = st.rstCnt - 8'd1;
    if (st.rstCnt2 != 8'd0)
      next_st.rstCnt2 = st.rstCnt2 - 8'd1;
    if (tick && runSweep)
    begin
      if (mode == DMS_POSPK || mode == DMS_NEGPK)
      begin
        if (frameStart)
          next_st.rstCnt = 8'(RST_CYC);
      end
      else if (mode == DMS_NORMAL)
      begin
        // Negative reset at frame start and 40 us later; the next frame
        // start falls 88 us after the second.
        if (frameStart || fUs == 8'(`DMS_NEG2_US))
          next_st.rstCnt2 = 8'(RST_CYC);
      end
    end
    next_st.posRstN = !(st.rstCnt != 8'd0);
    next_st.negRstN = !(st.rstCnt != 8'd0 || st.rstCnt2 != 8'd0);
    // Odd-bucket square wave toggles once per bucket.
    if (bucketEnd)
    begin
      next_st.oddOut = !st.oddOut;
      if (st.bucketNum == 10'(`DMS_BUCKETS - 1))
        next_st.bucketNum = '0;
      else
        next_st.bucketNum = st.bucketNum + 10'd1;
    end
    // Noise flag: both holding seen in one bucket, normal mode only.
    next_st.posSeen = st.posSeen | holdSync[1];
    next_st.negSeen = st.negSeen | holdSync[0];
    if (mode != DMS_NORMAL)
      next_st.noiseOut = 1'b0;
    else if (next_st.posSeen && next_st.negSeen)
      next_st.noiseOut = 1'b1;
    if (bucketEnd)
    begin
      next_st.posSeen = 1'b0;
      next_st.negSeen = 1'b0;
      if (!(holdSync[1] && holdSync[0]))
        next_st.noiseOut = 1'b0;
    end
    next_st.convIn = pickInput(mode, runSweep, wideSweep, diagRun,
      diagPick, st.oddOut);
  end

  // Reset restarts at the first bucket with resets released.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.posRstN <= 1'b1;
      st.negRstN <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign hold_strobe = st.holdOut;
  assign odd_bucket_toggle = st.oddOut;
  assign pos_peak_reset_n = st.posRstN;
  assign negative_peak_input_reset_n = st.negRstN;
  assign video_select_a = st.selA;
  assign video_select_b = st.selB;
  assign noise_flag = st.noiseOut;
  assign sweep_active = st.sweepOut;
  assign converter_clock = st.convClk;
  assign converter_input = st.convIn;
endmodule

/* rtl/dms_axil.sv */
`timescale 1ns/1ns
`include "dms_map.svh"
// AXI4-Lite slave holding the control and sweep setting registers.
module dms_axil
  import dms_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] statusWord,
  output logic [31:0] ctrlReg,
  output logic [31:0] sweepReg
);
  typedef struct packed
  {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] ctrl;
    logic [31:0] sweep;
  } dms_axil_t;
  dms_axil_t st;
  dms_axil_t next_st;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction

  // Address and data are caught independently; the write lands once both are
  // held and no response is pending. Unmapped addresses answer SLVERR.
  always_comb
  begin
    next_st = st;
    if (awvalid && !st.awHave)
    begin
      next_st.awHave = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && !st.wHave)
    begin
      next_st.wHave = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bValid && bready)
      next_st.bValid = 1'b0;
    if (st.awHave && st.wHave && !st.bValid)
    begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = 2'b00;
      unique case (st.awAddr)
        `DMS_ADDR_CTRL: next_st.ctrl = mergeBytes(st.ctrl, st.wData, st.wStrb);
        `DMS_ADDR_SWEEP:
          next_st.sweep = mergeBytes(st.sweep, st.wData, st.wStrb);
        `DMS_ADDR_STAT: next_st.bResp = 2'b00;
        default: next_st.bResp = 2'b10;
      endcase
    end
    if (st.rValid && rready)
      next_st.rValid = 1'b0;
    if (arvalid && !st.rValid)
    begin
      next_st.rValid = 1'b1;
      next_st.rResp = 2'b00;
      unique case (araddr)
        `DMS_ADDR_CTRL: next_st.rData = st.ctrl;
        `DMS_ADDR_SWEEP: next_st.rData = st.sweep;
        `DMS_ADDR_STAT: next_st.rData = statusWord;
        default:
        begin
          next_st.rData = 32'h0000_0000;
          next_st.rResp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.ctrl <= `DMS_CTRL_RST;
      st.sweep <= `DMS_SWEEP_RST;
    end
    else
      st <= next_st;
  end

  assign awready = !st.awHave;
  assign wready = !st.wHave;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign arready = !st.rValid;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;
  assign ctrlReg = st.ctrl;
  assign sweepReg = st.sweep;
endmodule

/* rtl/dms_map.svh */
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH
`define DMS_CLK_MHZ 125
`define DMS_CONV_MHZ 1
`define DMS_CONV_DIV (`DMS_CLK_MHZ / `DMS_CONV_MHZ)
`define DMS_FRAME_US 128
`define DMS_HOLD_US 18
`define DMS_SELA_US 15
`define DMS_SELB_US 40
`define DMS_NEG2_US 40
`define DMS_NEG3_US 128
`define DMS_RST_NS 200
`define DMS_RST_CYC ((`DMS_RST_NS * `DMS_CLK_MHZ) / 1000)
`define DMS_BUCKETS 600
`define DMS_ADDR_CTRL 8'h00
`define DMS_ADDR_SWEEP 8'h04
`define DMS_ADDR_STAT 8'h08
`define DMS_CTRL_RST 32'h0000_0000
`define DMS_SWEEP_RST 32'h0000_4E20
`endif

/* rtl/dms_pkg.sv */
package dms_pkg;
  typedef enum logic [1:0]
  {
    DMS_NORMAL = 2'b00,
    DMS_SAMPLE = 2'b01,
    DMS_POSPK = 2'b10,
    DMS_NEGPK = 2'b11
  } dms_mode_t;
  typedef enum logic [2:0]
  {
    DMS_IN_SAMPLED = 3'b000,
    DMS_IN_POSPK = 3'b001,
    DMS_IN_NEGPK = 3'b010,
    DMS_IN_RAMP = 3'b011,
    DMS_IN_TUNE = 3'b100,
    DMS_IN_FREQ_CONTROL_MUX_INPUT = 3'b101,
    DMS_IN_CAL = 3'b110,
    DMS_IN_OFFSET = 3'b111
  } dms_input_t;
endpackage

/* rtl/dms_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser for a bundle of pin levels.
module dms_sync
  import dms_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dms_sync_t;
  dms_sync_t st;
  dms_sync_t next_st;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_st = st;
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign syncOut = st.stage2;
endmodule

/* sim/dms_peak_model.sv */
`timescale 1ns/1ns
// Peak detector pair: a reset pulse empties a detector, which then
// reports holding again at the next converter tick, the negative one only with noisy video.
module dms_peak_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic converterClock,
  input wire logic posResetN,
  input wire logic negResetN,
  input wire logic noisy,
  output logic positive_holding,
  output logic negative_holding
);
  logic posHold = 1'b0;
  logic negHold = 1'b0;
  logic lastConv = 1'b0;
  // Quiet video only rises; noisy video makes both detectors hold.
  always @(posedge clk)
  begin
    lastConv <= converterClock;
    if (!rst_n || !posResetN)
      posHold <= 1'b0;
    else if (converterClock && !lastConv)
      posHold <= 1'b1;
    if (!rst_n || !negResetN)
      negHold <= 1'b0;
    else if (converterClock && !lastConv)
      negHold <= noisy;
  end
  assign positive_holding = posHold;
  assign negative_holding = negHold;
endmodule

/* sim/dms_seq_properties.sv */
`timescale 1ns/1ns
`include "dms_map.svh"
// Pin-level timing checks on the sequencer and its register bus.
module dms_seq_properties
#(
  parameter int FRAME_TICKS = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic hold_strobe,
  input wire logic pos_peak_reset_n,
  input wire logic negative_peak_input_reset_n,
  input wire logic noise_flag,
  input wire logic sweep_active,
  input wire logic converter_clock
);
  localparam int HOLD_CYC = `DMS_HOLD_US * `DMS_CLK_MHZ;
  localparam int CONV_CYC = `DMS_CONV_DIV;
  logic [15:0] holdCnt;
  logic [7:0] convCnt;
  logic convSeen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts hold strobe high time and cycles since the last converter tick.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      holdCnt <= 16'h0000;
      convCnt <= 8'h00;
      convSeen <= 1'b0;
    end
    else
    begin
      holdCnt <= hold_strobe ? holdCnt + 16'h0001 : 16'h0000;
      convCnt <= $rose(converter_clock) ? 8'h00 : convCnt + 8'h01;
      convSeen <= convSeen | $rose(converter_clock);
    end
  end
  // A negative peak reset pulse is low in its first 8 cycles and in its 25th, then high again.
  sequence s_neg_pulse;
    (!negative_peak_input_reset_n)[*8] ##17 !negative_peak_input_reset_n ##1 negative_peak_input_reset_n;
  endsequence
  property p_idle;
    @(posedge clk) disable iff (1'b0) !rst_n |=>
      pos_peak_reset_n && negative_peak_input_reset_n && !hold_strobe && !noise_flag;
  endproperty
  a_reset_idle: assert property (p_idle)
    else $error("outputs not idle after reset");
  a_hold_width: assert property ($fell(hold_strobe) && sweep_active |->
    holdCnt == HOLD_CYC) else $error("hold strobe width wrong");
  a_neg_pulse: assert property ($fell(negative_peak_input_reset_n) |-> s_neg_pulse)
    else $error("peak reset pulse width wrong");
  a_peak_pair: assert property ($fell(pos_peak_reset_n) |->
    $fell(negative_peak_input_reset_n)) else $error("peak resets not together");
  a_hold_sweep: assert property ($rose(hold_strobe) |-> ##[0:2]
    sweep_active) else $error("hold strobe outside sweep");
  a_conv_period: assert property ($rose(converter_clock) && convSeen |->
    convCnt == CONV_CYC - 1) else $error("converter clock period wrong");
  a_bresp_stable: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response dropped");
  a_rdata_stable: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data dropped");
  a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
    else $error("read not answered");
endmodule
bind detector_mode_sequencer dms_seq_properties
  #(.FRAME_TICKS(FRAME_TICKS)) dms_seq_properties_inst
  (.clk(clk), .rst_n(rst_n), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .hold_strobe(hold_strobe),
  .pos_peak_reset_n(pos_peak_reset_n), .negative_peak_input_reset_n(negative_peak_input_reset_n),
  .noise_flag(noise_flag), .sweep_active(sweep_active),
  .converter_clock(converter_clock));

/* sim/tb_detector_mode_sequencer.sv */
`timescale 1ns/1ns
`include "dms_map.svh"
module tb_detector_mode_sequencer
  import dms_pkg::*;
;
  localparam int US = `DMS_CLK_MHZ;
  logic clk = 1'b0, rst_n = 1'b0, noisy = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic hold_strobe, odd_bucket_toggle, pos_peak_reset_n, negative_peak_input_reset_n;
  logic video_select_a, video_select_b, noise_flag, sweep_active;
  logic converter_clock, positive_holding, negative_holding;
  logic [2:0] converter_input;
  int failures = 0, compares = 0;
  int g0, g1, g2, g3, g4, wa, wb;
  // Free-running system clock.
  initial
  begin
    forever #4 clk = ~clk;
  end
  detector_mode_sequencer #(.FRAME_TICKS(`DMS_FRAME_US))
    detector_mode_sequencer_inst (.clk(clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .positive_holding(positive_holding),
    .negative_holding(negative_holding), .hold_strobe(hold_strobe),
    .odd_bucket_toggle(odd_bucket_toggle),
    .pos_peak_reset_n(pos_peak_reset_n), .negative_peak_input_reset_n(negative_peak_input_reset_n),
    .video_select_a(video_select_a), .video_select_b(video_select_b),
    .noise_flag(noise_flag), .sweep_active(sweep_active),
    .converter_clock(converter_clock), .converter_input(converter_input));
  dms_peak_model dms_peak_model_inst (.clk(clk), .rst_n(rst_n),
    .converterClock(converter_clock), .posResetN(pos_peak_reset_n),
    .negResetN(negative_peak_input_reset_n), .noisy(noisy),
    .positive_holding(positive_holding), .negative_holding(negative_holding));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus write; address and data are released as each is taken.
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask
  // One bus read, checked against the expected word and response.
  task automatic axRead(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk(rdata, ed, "read data");
    chk(rresp, er, "read response");
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return video_select_a;
      1: return video_select_b;
      2: return negative_peak_input_reset_n;
      3: return pos_peak_reset_n;
      default: return odd_bucket_toggle;
    endcase
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic run,
    input logic wide, input logic diag, input logic [2:0] code);
    return {24'h00_0000, code, diag, wide, run, m};
  endfunction
  // Counts cycles until a pin changes, then until it reaches a level.
  task automatic waitChange(input int s, output int n);
    logic v;
    v = sig(s);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (sig(s) === v && n < 40000);
  endtask
  task automatic nextEdge(input int s, input logic lvl, output int n);
    int k;
    n = 0;
    do
    begin
      waitChange(s, k);
      n += k;
    end
    while (sig(s) !== lvl && n < 40000);
  endtask
  // Main sequence of register calls and pin checks.
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({pos_peak_reset_n, negative_peak_input_reset_n, hold_strobe, noise_flag},
      4'b1100, "reset levels");
    axRead(`DMS_ADDR_CTRL, `DMS_CTRL_RST, 2'b00);
    axRead(`DMS_ADDR_SWEEP, `DMS_SWEEP_RST, 2'b00);
    axRead(8'h0C, 32'h0000_0000, 2'b10);
    axWrite(8'h0C, 32'h0000_0001, 2'b10);
    axWrite(`DMS_ADDR_SWEEP, 32'h0000_0258, 2'b00);
    axWrite(`DMS_ADDR_CTRL, ctl(0, 1, 0, 0, 0), 2'b00);
    axRead(`DMS_ADDR_CTRL, ctl(0, 1, 0, 0, 0), 2'b00);
    waitChange(4, g0);
    waitChange(4, g0);
    chk(g0, US, "bucket length");
    chk(sweep_active, 1'b1, "sweep active");
    @(posedge clk);
    noisy <= 1'b1;
    repeat (400) @(negedge clk);
    chk(noise_flag, 1'b1, "noise seen");
    @(posedge clk);
    noisy <= 1'b0;
    fork
      begin
        nextEdge(2, 1'b0, g0);
        nextEdge(2, 1'b0, g1);
        nextEdge(2, 1'b0, g2);
      end
      begin
        nextEdge(0, 1'b1, g3);
        waitChange(0, wa);
      end
      begin
        nextEdge(1, 1'b1, g4);
        waitChange(1, wb);
      end
    join
    // A held negative detector empties at its next reset pulse or at the next converter tick with quiet video.
    repeat (4 * US) @(negedge clk);
    chk(noise_flag, 1'b0, "quiet video");
    chk((g1 == 40 * US && g2 == 88 * US) || (g1 == 88 * US && g2 == 40 * US),
      1'b1, "negative reset spacing");
    chk(wa, 15 * US, "select a width");
    chk(wb, 40 * US, "select b width");
    @(posedge clk);
    noisy <= 1'b1;
    for (int m = 1; m < 4; m++)
    begin
      axWrite(`DMS_ADDR_CTRL, ctl(m, 1, 0, 0, 0), 2'b00);
      repeat (300) @(negedge clk);
      chk(video_select_a, m != 3, "select a level");
      chk(video_select_b, m != 2, "select b level");
      chk(converter_input, m - 1, "mode input");
      chk(noise_flag, 1'b0, "noise outside normal");
      if (m == 2)
      begin
        nextEdge(3, 1'b0, g0);
        nextEdge(3, 1'b0, g1);
        chk(g1, 128 * US, "peak reset period");
      end
    end
    axWrite(`DMS_ADDR_CTRL, ctl(1, 1, 1, 0, 0), 2'b00);
    repeat (10) @(negedge clk);
    chk(converter_input, DMS_IN_RAMP, "ramp input");
    for (int c = 4; c < 8; c++)
    begin
      axWrite(`DMS_ADDR_CTRL, ctl(1, 1, 0, 1, c), 2'b00);
      repeat (10) @(negedge clk);
      chk(converter_input, c, "diagnostic input");
    end
    axWrite(`DMS_ADDR_CTRL, ctl(1, 1, 0, 0, 7), 2'b00);
    repeat (10) @(negedge clk);
    chk(converter_input, DMS_IN_SAMPLED, "diagnostic blocked");
    axWrite(`DMS_ADDR_CTRL, ctl(1, 0, 0, 0, 5), 2'b00);
    repeat (20 * US) @(negedge clk);
    chk(converter_input, DMS_IN_FREQ_CONTROL_MUX_INPUT, "retrace input");
    chk({sweep_active, hold_strobe}, 2'b00, "retrace levels");
    end_sim();
  end
  // Cuts a hung run short.
  initial
  begin
    #(95000 * 8);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
